/* verilog/flow_cond_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts for the flow conditioner
// Assumes: 32-bit AHB-Lite register words at byte addresses
// Notes:   Definitions only
`ifndef FLOW_COND_DEFS_SVH
`define FLOW_COND_DEFS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_FLOW_COEF   8'h04
`define OFS_DISP_COEF   8'h08
`define OFS_CUTOFF      8'h0C
`define OFS_STEP_THR    8'h10
`define OFS_UNIT        8'h14
`define OFS_PASSWORD    8'h18
`define OFS_ACCESS      8'h1C
`define OFS_MENU        8'h20
`define OFS_GLOBAL_CODE 8'h24
`define OFS_FLOW_OUT    8'h28
`define OFS_DISP_OUT    8'h2C
`define OFS_TOTAL       8'h30
`define OFS_IRQ_STATUS  8'h34
`define OFS_IRQ_CLEAR   8'h38
`define OFS_IRQ_ENABLE  8'h3C

// CTRL fields
`define CTRL_MODE_BIT   0
`define CTRL_VIEW_BIT   1
`define CTRL_KEYRST_BIT 2

// UNIT fields
`define UNIT_TYPE_LSB   0
`define UNIT_IDX_LSB    2
`define UNIT_CLASS_LSB  4

// Interrupt event bits
`define EV_BYPASS       0
`define EV_LOWFLOW      1
`define EV_FAULT        2
`define EV_DENIED       3
`define EV_COUNT        4

// Smoothing coefficient: fraction of 2^16 per sample
`define COEF_FRAC_BITS  16
`define COEF_ONE        17'h10000
`define SAMPLE_US       10000
`define FLOW_TAU_US     1000000
`define DISP_TAU_US     1000000
`define FLOW_COEF_RST   ((65536 * `SAMPLE_US) / `FLOW_TAU_US)
`define DISP_COEF_RST   ((65536 * `SAMPLE_US) / `DISP_TAU_US)

// Thresholds in thousandths of full scale
`define CUTOFF_PERMILLE 3
`define STEP_PERMILLE   990

// Lamp timing
`define CLK_PERIOD_PS   4000
`define BLINK_PERIOD_PS 64'd1000000000000
`define BLINK_HALF_CYC  ((`BLINK_PERIOD_PS / 2) / `CLK_PERIOD_PS)

`endif

/* verilog/flow_cond_pkg.sv */
// Purpose: Types shared by the flow conditioner
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in flow_cond_defs.svh
package flow_cond_pkg;
  typedef enum logic {MODE_MEASURE, MODE_CONTROL} op_mode_e;
  typedef enum logic [1:0] {MT_MASS, MT_VOLUME, MT_GAS, MT_OIL} meter_type_e;
  typedef enum logic [2:0] {MENU_NONE, MENU_DISPLAY, MENU_ZERO, MENU_SETUP,
                            MENU_IOTEST, MENU_SERVICE, MENU_FACTORY} menu_e;
  typedef logic [1:0] unit_class_t;
endpackage : flow_cond_pkg

/* verilog/flow_cond.sv */
// Purpose: Flow rate smoothing, low-flow zeroing, totalizer, lamps, modes and menu gating
// Assumes: One flow sample per FLOW_VALID pulse; AHB-Lite register access
// Notes:   Config writes need the matching menu to be open
//
// Functional notes
// - The OK lamp blinks at one second while healthy and the fault lamp blinks on a fault.
// - Measuring mode gives fixed button functions; control mode turns three buttons into softkeys.
// - Changing the display view never changes the measurement or any output value.
// - Zero, setup and test menus need the user password; service and factory need their own.
// - A configured global access code refuses control mode until the code is given.
// - Meter type limits unit class: mass, volume for volume or oil, standard volume for gas.
// - Each smoother is a linear first-order lag with a settable time constant.
// - The primary smoother feeds totalizer and rate outputs; one second is the default.
// - The readout smoother follows the primary one and only drives the displayed rate.
// - Below the low-flow threshold the rate reads zero and totals stay still.
// - The low-flow threshold resets to 0.3 percent of full scale.
// - A jump larger than the bypass threshold reloads the primary smoother with the input.
// - The bypass threshold resets to 99 percent of full scale.
`timescale 1ns/1ps
`include "flow_cond_defs.svh"

module flow_cond
  import flow_cond_pkg::*;
#(
  parameter int          W          = 24,
  parameter int          FULL_SCALE = 8000000,
  parameter int unsigned HALF_BLINK = 32'(`BLINK_HALF_CYC),
  parameter logic [15:0] USER_PW    = 16'h1A2B,  // Arbitrary value
  parameter logic [15:0] SERVICE_PW = 16'h3C4D,  // Arbitrary value
  parameter logic [15:0] FACTORY_PW = 16'h5E6F   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                MCLK,
  input  wire logic                RESET,
  // AHB-Lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  // Flow samples
  input  wire logic signed [W-1:0] FLOW_IN,
  input  wire logic                FLOW_VALID,
  // Pins
  input  wire logic                FAULT,
  input  wire logic [3:0]          BUTTONS,
  // Outputs
  output logic signed [W-1:0]      FLOW_OUT,
  output logic signed [W-1:0]      DISP_FLOW,
  output logic [47:0]              TOTAL,
  output logic                     VIEW,
  output logic [2:0]               SOFTKEY,
  output logic                     LED_OK,
  output logic                     LED_ERR,
  output logic                     IRQ
);
  initial begin
    if (W < 8 || W > 30 || FULL_SCALE >= (1 << (W - 1)) || HALF_BLINK < 2)
      $error("flow_cond: unsupported parameters");
  end

  localparam logic [W-1:0] CUT_RST  = W'((64'(FULL_SCALE) * `CUTOFF_PERMILLE) / 1000);
  localparam logic [W-1:0] STEP_RST = W'((64'(FULL_SCALE) * `STEP_PERMILLE) / 1000);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
    end else begin
      pin_s1_q <= {FAULT, BUTTONS};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  wire       fault_s  = pin_s2_q[4];
  wire [3:0] btn_rise = pin_s2_q[3:0] & ~pin_s3_q[3:0];
  wire       fault_rise = fault_s & ~pin_s3_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  op_mode_e     mode_q, mode_d;
  logic         view_q, view_d, keyrst_q, keyrst_d;
  logic [16:0]  fcoef_q, fcoef_d, dcoef_q, dcoef_d;
  logic [W-1:0] cut_q, cut_d, step_q, step_d;
  logic [5:0]   unit_q, unit_d;
  logic [2:0]   lvl_q, lvl_d;          // user, service, factory
  menu_e        menu_q, menu_d;
  logic [15:0]  gcode_q, gcode_d;
  logic         glock_q, glock_d;
  logic [3:0]   ien_q, ien_d, ist_q, ist_d;
  logic [2:0]   soft_q, soft_d;
  logic         denied;
  logic [`EV_COUNT-1:0] ev;

  // Bus pipeline
  logic        ph_q, ph_d, phw_q, phw_d, rdy_q, rdy_d;
  logic [7:0]  pa_q, pa_d;
  logic [31:0] rd_q, rd_d;

  // Flow path
  logic signed [W-1:0] y_q, y_d, z_q, z_d, out_q, out_d, dsp_q, dsp_d;
  logic [47:0]         tot_q, tot_d;
  logic                low_q, low_d, byp;

  function automatic logic signed [W-1:0] lag_step(input logic signed [W-1:0] x,
                                                  input logic signed [W-1:0] y,
                                                  input logic [16:0]         c);
    logic signed [W:0]    diff;
    logic signed [W+18:0] prod;
    diff = (W+1)'(x) - (W+1)'(y);
    prod = diff * $signed({1'b0, c});
    lag_step = W'(y + W'(prod >>> `COEF_FRAC_BITS));
  endfunction : lag_step

  function automatic unit_class_t class_of(input logic [1:0] t);
    unique case (meter_type_e'(t))
      MT_MASS:           class_of = 2'd0;
      MT_VOLUME, MT_OIL: class_of = 2'd1;
      MT_GAS:            class_of = 2'd2;
    endcase
  endfunction : class_of

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave and configuration
  wire       take = HSEL & HTRANS[1] & HREADY;
  wire       wr   = ph_q & phw_q;
  wire [1:0] wtype = HWDATA[`UNIT_TYPE_LSB +: 2];

  always_comb begin
    ph_d = take ? 1'b1 : (rdy_q ? 1'b0 : ph_q);
    phw_d = take ? HWRITE : phw_q;
    pa_d  = take ? HADDR[7:0] : pa_q;
    rdy_d = ~(take & ~HWRITE);
    rd_d  = rd_q;
    mode_d = mode_q; view_d = view_q; keyrst_d = keyrst_q;
    fcoef_d = fcoef_q; dcoef_d = dcoef_q; cut_d = cut_q; step_d = step_q;
    unit_d = unit_q; lvl_d = lvl_q; menu_d = menu_q;
    gcode_d = gcode_q; glock_d = glock_q; ien_d = ien_q;
    soft_d = 3'h0;
    denied = 1'b0;
    if (ph_q & ~phw_q & ~rdy_q) begin
      unique case (pa_q)
        `OFS_CTRL:        rd_d = 32'({keyrst_q, view_q, mode_q == MODE_CONTROL});
        `OFS_FLOW_COEF:   rd_d = 32'(fcoef_q);
        `OFS_DISP_COEF:   rd_d = 32'(dcoef_q);
        `OFS_CUTOFF:      rd_d = 32'(cut_q);
        `OFS_STEP_THR:    rd_d = 32'(step_q);
        `OFS_UNIT:        rd_d = 32'(unit_q);
        `OFS_ACCESS:      rd_d = 32'({glock_q, lvl_q});
        `OFS_MENU:        rd_d = 32'(menu_q);
        `OFS_GLOBAL_CODE: rd_d = 32'(gcode_q != 16'h0000);
        `OFS_FLOW_OUT:    rd_d = 32'(unsigned'(out_q));
        `OFS_DISP_OUT:    rd_d = 32'(unsigned'(dsp_q));
        `OFS_TOTAL:       rd_d = tot_q[31:0];
        `OFS_IRQ_STATUS:  rd_d = 32'(ist_q);
        `OFS_IRQ_ENABLE:  rd_d = 32'(ien_q);
        default:          rd_d = 32'h0000_0000;
      endcase
    end
    // Measuring mode: fixed buttons; control mode: softkeys
    if (mode_q == MODE_MEASURE) begin
      if (btn_rise[1]) view_d = ~view_q;
    end else begin
      soft_d = btn_rise[2:0];
    end
    if (wr) begin
      unique case (pa_q)
        `OFS_CTRL: begin
          view_d   = HWDATA[`CTRL_VIEW_BIT];
          keyrst_d = HWDATA[`CTRL_KEYRST_BIT];
          if (HWDATA[`CTRL_MODE_BIT] & glock_q) denied = 1'b1;
          else if (HWDATA[`CTRL_MODE_BIT]) mode_d = MODE_CONTROL;
          else begin
            mode_d = MODE_MEASURE;
            menu_d = MENU_NONE;
            lvl_d  = 3'h0;
          end
        end
        `OFS_PASSWORD: begin
          if (glock_q && HWDATA[15:0] == gcode_q) glock_d = 1'b0;
          else if (mode_q != MODE_CONTROL) denied = 1'b1;
          else if (HWDATA[15:0] == USER_PW)    lvl_d[0] = 1'b1;
          else if (HWDATA[15:0] == SERVICE_PW) lvl_d[1] = 1'b1;
          else if (HWDATA[15:0] == FACTORY_PW) lvl_d[2] = 1'b1;
          else denied = 1'b1;
        end
        `OFS_MENU: begin
          if (mode_q != MODE_CONTROL) denied = 1'b1;
          else begin
            unique case (menu_e'(HWDATA[2:0]))
              MENU_NONE:    begin menu_d = MENU_NONE; lvl_d = 3'h0; end
              MENU_DISPLAY: menu_d = MENU_DISPLAY;
              MENU_ZERO, MENU_SETUP, MENU_IOTEST:
                if (lvl_q[0]) menu_d = menu_e'(HWDATA[2:0]);
                else denied = 1'b1;
              MENU_SERVICE: if (lvl_q[1]) menu_d = MENU_SERVICE; else denied = 1'b1;
              MENU_FACTORY: if (lvl_q[2]) menu_d = MENU_FACTORY; else denied = 1'b1;
              default:      denied = 1'b1;
            endcase
          end
        end
        `OFS_FLOW_COEF:   if (menu_q == MENU_SETUP) fcoef_d = HWDATA[16:0];
                          else denied = 1'b1;
        `OFS_CUTOFF:      if (menu_q == MENU_SETUP) cut_d = HWDATA[W-1:0];
                          else denied = 1'b1;
        `OFS_STEP_THR:    if (menu_q == MENU_SETUP) step_d = HWDATA[W-1:0];
                          else denied = 1'b1;
        `OFS_DISP_COEF:   if (menu_q == MENU_DISPLAY) dcoef_d = HWDATA[16:0];
                          else denied = 1'b1;
        `OFS_UNIT:
          if (menu_q == MENU_SETUP && class_of(wtype) == HWDATA[`UNIT_CLASS_LSB +: 2])
            unit_d = HWDATA[5:0];
          else denied = 1'b1;
        `OFS_GLOBAL_CODE: if (menu_q == MENU_SERVICE) gcode_d = HWDATA[15:0];
                          else denied = 1'b1;
        `OFS_IRQ_ENABLE:  ien_d = HWDATA[3:0];
        default: ;
      endcase
    end
    // Lock arms on leaving control mode, so a supplied code lets one entry through
    if (gcode_d != 16'h0000 && mode_q == MODE_CONTROL && mode_d == MODE_MEASURE)
      glock_d = 1'b1;
  end

  // Interrupt status: a new event wins over its clear
  always_comb begin
    ev = '0;
    ev[`EV_BYPASS]  = byp;
    ev[`EV_LOWFLOW] = low_d & ~low_q;
    ev[`EV_FAULT]   = fault_rise;
    ev[`EV_DENIED]  = denied;
    ist_d = ist_q;
    if (wr && pa_q == `OFS_IRQ_CLEAR) ist_d = ist_q & ~HWDATA[3:0];
    ist_d = ist_d | ev;
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ph_q <= 1'b0; phw_q <= 1'b0; pa_q <= 8'h00; rdy_q <= 1'b1; rd_q <= 32'h0000_0000;
      mode_q <= MODE_MEASURE; view_q <= 1'b0; keyrst_q <= 1'b1;
      fcoef_q <= 17'(`FLOW_COEF_RST);
      dcoef_q <= 17'(`DISP_COEF_RST);
      cut_q <= CUT_RST;
      step_q <= STEP_RST;
      unit_q <= 6'h00; lvl_q <= 3'h0; menu_q <= MENU_NONE;
      gcode_q <= 16'h0000; glock_q <= 1'b0;
      ien_q <= 4'h0; ist_q <= 4'h0; soft_q <= 3'h0;
    end else begin
      ph_q <= ph_d; phw_q <= phw_d; pa_q <= pa_d; rdy_q <= rdy_d; rd_q <= rd_d;
      mode_q <= mode_d; view_q <= view_d; keyrst_q <= keyrst_d;
      fcoef_q <= fcoef_d; dcoef_q <= dcoef_d; cut_q <= cut_d; step_q <= step_d;
      unit_q <= unit_d; lvl_q <= lvl_d; menu_q <= menu_d;
      gcode_q <= gcode_d; glock_q <= glock_d;
      ien_q <= ien_d; ist_q <= ist_d; soft_q <= soft_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow path: primary smoother, bypass, low-flow, totalizer, readout smoother
  logic signed [W:0] jump;
  logic [W:0]        jump_abs;
  logic signed [W-1:0] ylag;
  always_comb begin
    jump     = (W+1)'(FLOW_IN) - (W+1)'(y_q);
    jump_abs = jump[W] ? (W+1)'(-jump) : (W+1)'(jump);
    ylag     = lag_step(FLOW_IN, y_q, fcoef_q);
    byp      = FLOW_VALID && (jump_abs > {1'b0, step_q});
    y_d = y_q; z_d = z_q; out_d = out_q; dsp_d = dsp_q; tot_d = tot_q; low_d = low_q;
    if (FLOW_VALID) begin
      y_d   = byp ? FLOW_IN : ylag;
      low_d = ((y_d[W-1] ? -y_d : y_d) < signed'(cut_q));
      out_d = low_d ? '0 : y_d;
      z_d   = lag_step(y_d, z_q, dcoef_q);
      dsp_d = low_d ? '0 : z_d;
      tot_d = low_d ? tot_q : tot_q + 48'(out_d);
    end
    if (mode_q == MODE_MEASURE && btn_rise[0] && keyrst_q) tot_d = 48'h0;
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      y_q <= '0; z_q <= '0; out_q <= '0; dsp_q <= '0; tot_q <= 48'h0; low_q <= 1'b1;
    end else begin
      y_q <= y_d; z_q <= z_d; out_q <= out_d; dsp_q <= dsp_d; tot_q <= tot_d; low_q <= low_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamps and interrupt output
  logic [31:0] blk_q, blk_d;
  logic        ok_q, ok_d, err_q, err_d, irq_q, irq_d;
  always_comb begin
    blk_d = (blk_q == 32'(HALF_BLINK - 1)) ? 32'h0 : blk_q + 32'h1;
    ok_d  = ok_q;
    err_d = err_q;
    if (fault_s) begin
      ok_d = 1'b0;
      if (blk_d == 32'h0) err_d = ~err_q;
    end else begin
      err_d = 1'b0;
      if (blk_d == 32'h0) ok_d = ~ok_q;
    end
    irq_d = |(ist_d & ien_d);
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      blk_q <= 32'h0; ok_q <= 1'b0; err_q <= 1'b0; irq_q <= 1'b0;
    end else begin
      blk_q <= blk_d; ok_q <= ok_d; err_q <= err_d; irq_q <= irq_d;
    end
  end

  assign HRDATA    = rd_q;
  assign HREADYOUT = rdy_q;
  assign HRESP     = 1'b0;
  assign FLOW_OUT  = out_q;
  assign DISP_FLOW = dsp_q;
  assign TOTAL     = tot_q;
  assign VIEW      = view_q;
  assign SOFTKEY   = soft_q;
  assign LED_OK    = ok_q;
  assign LED_ERR   = err_q;
  assign IRQ       = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  chk_bypass_reload: assert property (byp |=> y_q == $past(FLOW_IN))
    else $error("bypass did not reload smoother");
  chk_cutoff_zero: assert property (FLOW_VALID && low_d |=> out_q == 0 && dsp_q == 0)
    else $error("low flow not forced to zero");
  chk_total_hold: assert property (FLOW_VALID && low_d && !btn_rise[0] |=> $stable(tot_q))
    else $error("total moved during low flow");
  chk_lamp_fault: assert property (fault_s |=> !ok_q)
    else $error("ok lamp lit during fault");
  chk_lamp_ok: assert property (!fault_s |=> !err_q)
    else $error("fault lamp lit while healthy");
  chk_view_isolation: assert property (!$past(FLOW_VALID) && $changed(view_q)
                                       |-> $stable(out_q))
    else $error("view change moved output");
  chk_softkey_mode: assert property (mode_q == MODE_MEASURE |=> soft_q == 3'h0)
    else $error("softkey pulse in measuring mode");
  chk_menu_gate: assert property (menu_q inside {MENU_ZERO, MENU_SETUP, MENU_IOTEST}
                                  |-> lvl_q[0])
    else $error("protected menu open without password");
  chk_global_lock: assert property (glock_q && mode_q == MODE_MEASURE
                                    |=> mode_q == MODE_MEASURE)
    else $error("control mode entered while locked");
  chk_unit_class: assert property ($changed(unit_q) |-> class_of(unit_q[1:0])
                                   == unit_q[5:4])
    else $error("unit class does not match meter type");
  chk_lag_bound: assert property (FLOW_VALID && !byp && FLOW_IN > y_q
                                  |=> y_q <= $past(FLOW_IN))
    else $error("smoother overshot its input");
endmodule : flow_cond

/* verif/flow_operator.sv */
// Purpose: Operator at the pushbuttons of the flow conditioner
// Assumes: Presses outlast the pin synchroniser
// Notes:   Buttons are released between presses
`timescale 1ns/1ps

module flow_operator #(
  parameter int ON_FLOW = 200000
) (
  // Clock
  input  wire logic       MCLK,
  // Pins
  output logic      [3:0] BUTTONS
);
  // Half the on-flow suits on/off duty
  localparam int STEP_PICK = ON_FLOW / 2;

  initial BUTTONS = 4'h0;

  // Long hold so one press gives exactly one edge
  task automatic press(input int b);
    BUTTONS[b] <= 1'b1;
    repeat (6) @(posedge MCLK);
    BUTTONS <= 4'h0;
    repeat (6) @(posedge MCLK);
  endtask : press
endmodule : flow_operator

/* verif/flow_cond_tb_top.sv */
// Purpose: Self-checking bench for flow_cond
// Assumes: Blink half period shortened to 8 cycles
// Notes:   Bus tasks do single word AHB-Lite transfers
`timescale 1ns/1ps
`include "flow_cond_defs.svh"

module flow_cond_tb_top;
  // Passwords are arbitrary values
  localparam logic [15:0] UPW = 16'h1A2B;
  localparam logic [15:0] SPW = 16'h3C4D;
  localparam int          FS  = 8000000;
  localparam int          HB  = 8;

  logic                MCLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP;
  logic                FLOW_VALID, FAULT, VIEW, LED_OK, LED_ERR, IRQ;
  logic [31:0]         HADDR, HWDATA, HRDATA, r;
  logic [1:0]          HTRANS;
  logic signed [23:0]  FLOW_IN, FLOW_OUT, DISP_FLOW, d0;
  logic [47:0]         TOTAL, t0;
  logic [3:0]          BUTTONS;
  logic [2:0]          SOFTKEY, sk_seen;
  logic                sk_clr;
  int                  miscompares, comparisons;

  flow_cond #(.FULL_SCALE(FS), .HALF_BLINK(HB), .USER_PW(UPW), .SERVICE_PW(SPW)) i_dut (
    .MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FLOW_IN(FLOW_IN),
    .FLOW_VALID(FLOW_VALID), .FAULT(FAULT), .BUTTONS(BUTTONS), .FLOW_OUT(FLOW_OUT),
    .DISP_FLOW(DISP_FLOW), .TOTAL(TOTAL), .VIEW(VIEW), .SOFTKEY(SOFTKEY),
    .LED_OK(LED_OK), .LED_ERR(LED_ERR), .IRQ(IRQ));

  flow_operator #(.ON_FLOW(200000)) i_op (.MCLK(MCLK), .BUTTONS(BUTTONS));

  always #2 MCLK = ~MCLK;

  // Softkey pulses last one cycle, so collect them
  always @(posedge MCLK) sk_seen <= sk_clr ? 3'h0 : (sk_seen | SOFTKEY);

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 40);
    if (HREADYOUT !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    r = HRDATA;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(a, 1'b0, 32'h0);
    chk(r, e, m);
    chk(HRESP, 1'b0, "bus response");
  endtask : rd

  task automatic smp(input int x);
    FLOW_IN <= 24'(x);
    FLOW_VALID <= 1'b1;
    @(posedge MCLK);
    FLOW_VALID <= 1'b0;
    @(posedge MCLK);
    #1;
  endtask : smp

  // Counts cycles between two toggles of one lamp
  task automatic blink(input bit e);
    logic v;
    int   n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      v = e ? LED_ERR : LED_OK;
      while ((e ? LED_ERR : LED_OK) === v && n < 40) begin
        @(posedge MCLK);
        #1;
        n++;
      end
    end
    chk(n, HB, "lamp half period");
    if (n >= 40) end_of_test();
  endtask : blink

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    MCLK = 0;
    RESET = 1;
    {HSEL, HWRITE, FLOW_VALID, FAULT} = 4'h0;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    HTRANS = 2'h0;
    FLOW_IN = 24'h0;
    sk_clr = 1'b1;
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    sk_clr <= 1'b0;
    @(posedge MCLK);
    rd(`OFS_CTRL, 32'h4, "ctrl reset");
    rd(`OFS_FLOW_COEF, 65536 / 100, "flow coef reset");
    rd(`OFS_DISP_COEF, 65536 / 100, "disp coef reset");
    rd(`OFS_CUTOFF, FS * 3 / 1000, "low flow reset");
    rd(`OFS_STEP_THR, FS / 100 * 99, "bypass reset");
    rd(8'h40, 32'h0, "unmapped read");
    wr(`OFS_STEP_THR, i_op.STEP_PICK);
    rd(`OFS_STEP_THR, FS / 100 * 99, "locked config write");
    rd(`OFS_IRQ_STATUS, 32'h8, "denied event");
    wr(`OFS_IRQ_CLEAR, 32'hF);
    wr(`OFS_CTRL, 32'h5);
    wr(`OFS_PASSWORD, UPW);
    rd(`OFS_ACCESS, 32'h1, "user level");
    wr(`OFS_MENU, 32'h3);
    i_op.press(0);
    chk(sk_seen, 3'h1, "softkey in control");
    wr(`OFS_UNIT, 32'h10);
    rd(`OFS_UNIT, 32'h0, "mass type volume unit");
    wr(`OFS_UNIT, 32'h26);
    rd(`OFS_UNIT, 32'h26, "gas type std unit");
    wr(`OFS_STEP_THR, i_op.STEP_PICK);
    rd(`OFS_STEP_THR, 100000, "bypass write");
    wr(`OFS_IRQ_ENABLE, 32'h3);
    smp(1000000);
    chk(FLOW_OUT, 1000000, "jump reload");
    chk(DISP_FLOW > 0 && DISP_FLOW < FLOW_OUT, 1, "readout lags");
    chk(IRQ, 1, "irq on bypass");
    t0 = TOTAL;
    smp(1050000);
    chk(FLOW_OUT, 1000000 + 50000 * 655 / 65536, "linear lag step");
    chk(TOTAL > t0, 1, "total grows");
    rd(`OFS_FLOW_OUT, 1000499, "flow out register");
    rd(`OFS_TOTAL, 2000499, "total register");
    wr(`OFS_CTRL, 32'h4);
    {t0, d0} = {TOTAL, DISP_FLOW};
    sk_clr <= 1'b1;
    @(posedge MCLK);
    sk_clr <= 1'b0;
    i_op.press(1);
    i_op.press(2);
    chk(VIEW, 1, "view toggled");
    chk(sk_seen, 3'h0, "no softkey measuring");
    chk({FLOW_OUT, DISP_FLOW, TOTAL}, {24'(1000499), d0, t0}, "view side effect");
    wr(`OFS_IRQ_CLEAR, 32'h3);
    repeat (2) @(posedge MCLK);
    #1;
    chk(IRQ, 0, "irq cleared");
    t0 = TOTAL;
    smp(0);
    chk({FLOW_OUT, TOTAL}, {24'h0, t0}, "low flow zero");
    smp(20000);
    chk({FLOW_OUT, DISP_FLOW, TOTAL}, {48'h0, t0}, "low flow hold");
    rd(`OFS_FLOW_OUT, 32'h0, "flow out register zero");
    // Denied bit from the refused unit write is still pending
    rd(`OFS_IRQ_STATUS, 32'hB, "bypass and low events");
    chk(IRQ, 1, "irq raised");
    wr(`OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge MCLK);
    #1;
    chk(IRQ, 0, "irq masked");
    wr(`OFS_CTRL, 32'h5);
    wr(`OFS_PASSWORD, SPW);
    wr(`OFS_MENU, 32'h5);
    wr(`OFS_GLOBAL_CODE, 32'h55);
    rd(`OFS_GLOBAL_CODE, 32'h1, "code set");
    wr(`OFS_CTRL, 32'h4);
    repeat (3) @(posedge MCLK);
    wr(`OFS_CTRL, 32'h5);
    rd(`OFS_CTRL, 32'h4, "control refused");
    rd(`OFS_ACCESS, 32'h8, "lock shown");
    wr(`OFS_PASSWORD, 32'h55);
    wr(`OFS_CTRL, 32'h5);
    rd(`OFS_CTRL, 32'h5, "control after code");
    blink(1'b0);
    FAULT <= 1'b1;
    repeat (6) @(posedge MCLK);
    blink(1'b1);
    chk(LED_OK, 0, "ok lamp dark on fault");
    end_of_test();
  end
endmodule : flow_cond_tb_top
